// >>> logic/ssm_pkg.sv
// Package for the synchronous serial block: register map, fields, counts.
// Assumes an APB slave with 32-bit data and one register per aligned word.
package ssm_pkg;
    // Register byte addresses
    localparam logic [7:0] SSM_OFF_FLAGS = 8'h00;
    localparam logic [7:0] SSM_OFF_ENABLES = 8'h04;
    localparam logic [7:0] SSM_OFF_RX_STAT = 8'h08;
    localparam logic [7:0] SSM_OFF_TX_BUF = 8'h0c;
    localparam logic [7:0] SSM_OFF_TX_STAT = 8'h10;
    localparam logic [7:0] SSM_OFF_BAUD_CTL = 8'h14;
    localparam logic [7:0] SSM_OFF_DIV_HIGH = 8'h18;
    localparam logic [7:0] SSM_OFF_DIV_LOW = 8'h1c;
    localparam logic [7:0] SSM_OFF_RX_BUF = 8'h20;
    // Flag and enable register fields
    localparam int SSM_BIT_RX_DONE = 5;
    localparam int SSM_BIT_TX_EMPTY = 4;
    // Receive status/control fields
    localparam int SSM_BIT_PORT_EN = 7;
    localparam int SSM_BIT_RX9 = 6;
    localparam int SSM_BIT_SINGLE_RX = 5;
    localparam int SSM_BIT_CONT_RX = 4;
    localparam int SSM_BIT_OVERRUN = 1;
    localparam int SSM_BIT_RX9_DATA = 0;
    // Transmit status/control fields
    localparam int SSM_BIT_CLK_SRC = 7;
    localparam int SSM_BIT_TX9 = 6;
    localparam int SSM_BIT_TX_EN = 5;
    localparam int SSM_BIT_SYNC = 4;
    localparam int SSM_BIT_SHIFT_EMPTY = 1;
    localparam int SSM_BIT_TX9_DATA = 0;
    // Baud control fields
    localparam int SSM_BIT_CLK_POL = 4;
    localparam int SSM_BIT_WIDE_DIV = 3;
    // Reset values
    localparam logic [7:0] SSM_RST_TX_STAT = 8'h02;
    localparam logic [7:0] SSM_RST_ZERO = 8'h00;
    // Bits in a word
    localparam logic [3:0] SSM_BITS_8 = 4'h8;
    localparam logic [3:0] SSM_BITS_9 = 4'h9;
    // Shifter states
    typedef enum logic [1:0] {SSM_IDLE, SSM_LOAD, SSM_TX, SSM_RX} ssm_state_t;
endpackage : ssm_pkg

// >>> logic/ssm_sync_serial.sv
// Synchronous half-duplex serial port, master and slave, behind an APB slave.
// Assumes the external shift clock and data pins are asynchronous to pclk.
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
module ssm_sync_serial
    import ssm_pkg::*;
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Shift clock pin
    input wire logic shift_clock_pin_i,
    output logic shift_clock_pin_o,
    output logic shift_clock_pin_oe,
    // Serial data pin
    input wire logic serial_data_pin_i,
    output logic serial_data_pin_o,
    output logic serial_data_pin_oe,
    // Interrupt requests
    output logic tx_irq,
    output logic rx_irq
);
    // Registers
    logic [7:0] enables_q;
    logic [7:0] rx_ctl_q;
    logic [7:0] tx_ctl_q;
    logic [7:0] baud_ctl_q;
    logic [7:0] div_high_q;
    logic [7:0] div_low_q;
    logic [7:0] tx_buf_q;
    logic [7:0] rx_buf_q;
    logic rx9_q;
    logic overrun_q;
    logic tx_empty_q;
    logic rx_done_q;
    // Shifter
    ssm_state_t state_q;
    logic [8:0] shift_q;
    logic [3:0] bit_cnt_q;
    logic [15:0] baud_cnt_q;
    logic phase_q;
    logic sck_q;
    logic data_out_q;
    logic tx_on_q;
    logic tx_on2_q;
    // Synchronisers
    logic [1:0] ck_sync_q;
    logic [1:0] dt_sync_q;
    logic ck_prev_q;

    // Decoded controls
    logic port_on;
    logic master;
    logic cont_rx;
    logic rx_want;
    logic [3:0] word_bits;
    logic wr_acc;
    logic rd_acc;
    logic buf_write;
    logic rx_read;
    logic addr_ok;
    logic tick;
    logic ext_rise;
    logic ext_fall;
    logic lead_edge;
    logic samp_edge;
    logic word_end;
    logic [15:0] div_val;

    assign port_on = rx_ctl_q[SSM_BIT_PORT_EN] & tx_ctl_q[SSM_BIT_SYNC];
    assign master = port_on & tx_ctl_q[SSM_BIT_CLK_SRC];
    assign cont_rx = rx_ctl_q[SSM_BIT_CONT_RX];
    // Either enable asks for reception
    assign rx_want = rx_ctl_q[SSM_BIT_SINGLE_RX] | cont_rx;
    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & penable & ~pwrite;
    assign buf_write = wr_acc & (paddr == SSM_OFF_TX_BUF);
    assign rx_read = rd_acc & (paddr == SSM_OFF_RX_BUF);
    assign div_val = baud_ctl_q[SSM_BIT_WIDE_DIV] ? {div_high_q, div_low_q}
                                                  : {8'h00, div_low_q};

    // Address decode for unmapped answer
    always_comb begin
        case (paddr)
            SSM_OFF_FLAGS, SSM_OFF_ENABLES, SSM_OFF_RX_STAT, SSM_OFF_TX_BUF,
            SSM_OFF_TX_STAT, SSM_OFF_BAUD_CTL, SSM_OFF_DIV_HIGH, SSM_OFF_DIV_LOW,
            SSM_OFF_RX_BUF: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // Pin synchronisers, two stages each
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ck_sync_q <= 2'b00;
            dt_sync_q <= 2'b00;
            ck_prev_q <= 1'b0;
        end else begin
            ck_sync_q <= {ck_sync_q[0], shift_clock_pin_i};
            dt_sync_q <= {dt_sync_q[0], serial_data_pin_i};
            ck_prev_q <= ck_sync_q[1];
        end
    end

    // Slave edges from the external clock; only clock changes move the shifter
    assign ext_rise = ck_sync_q[1] & ~ck_prev_q;
    assign ext_fall = ~ck_sync_q[1] & ck_prev_q;

    // Baud tick: one half shift-clock period per divisor+1 cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_cnt_q <= 16'h0000;
        end else if (!master || state_q == SSM_IDLE || state_q == SSM_LOAD || tick) begin
            baud_cnt_q <= 16'h0000;
        end else begin
            baud_cnt_q <= baud_cnt_q + 16'h0001;
        end
    end
    assign tick = master && (state_q == SSM_TX || state_q == SSM_RX)
                  && (baud_cnt_q == div_val);

    // Leading edge rises, sampling edge falls (shift clock sense before polarity)
    assign lead_edge = master ? (tick & ~phase_q) : ext_rise;
    assign samp_edge = master ? (tick & phase_q) : ext_fall;
    assign word_end = samp_edge && (bit_cnt_q == 4'h1);

    // Word length per direction
    always_comb begin
        if (state_q == SSM_RX) begin
            word_bits = rx_ctl_q[SSM_BIT_RX9] ? SSM_BITS_9 : SSM_BITS_8;
        end else begin
            word_bits = tx_ctl_q[SSM_BIT_TX9] ? SSM_BITS_9 : SSM_BITS_8;
        end
    end

    // Shifter state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= SSM_IDLE;
            shift_q <= 9'h000;
            bit_cnt_q <= 4'h0;
            phase_q <= 1'b0;
            data_out_q <= 1'b0;
        end else if (!port_on) begin
            state_q <= SSM_IDLE;
            phase_q <= 1'b0;
        end else begin
            case (state_q)
                SSM_IDLE: begin
                    phase_q <= 1'b0;
                    // Pending transmit first; reception waits for the line
                    if (tx_ctl_q[SSM_BIT_TX_EN] && !tx_empty_q) begin
                        state_q <= SSM_LOAD;
                    end else if (rx_want && !tx_ctl_q[SSM_BIT_TX_EN]) begin
                        state_q <= SSM_RX;
                        bit_cnt_q <= rx_ctl_q[SSM_BIT_RX9] ? SSM_BITS_9 : SSM_BITS_8;
                    end
                end
                SSM_LOAD: begin
                    // One-cycle move from buffer into hidden shifter
                    shift_q <= {tx_ctl_q[SSM_BIT_TX9_DATA], tx_buf_q};
                    bit_cnt_q <= word_bits;
                    state_q <= SSM_TX;
                end
                SSM_TX: begin
                    if (lead_edge) begin
                        data_out_q <= shift_q[0];
                        phase_q <= 1'b1;
                    end
                    if (samp_edge) begin
                        shift_q <= {1'b0, shift_q[8:1]};
                        bit_cnt_q <= bit_cnt_q - 4'h1;
                        phase_q <= 1'b0;
                        if (bit_cnt_q == 4'h1) begin
                            // Back-to-back load if a new word waits
                            state_q <= (!tx_empty_q && tx_ctl_q[SSM_BIT_TX_EN])
                                       ? SSM_LOAD : SSM_IDLE;
                        end
                    end
                end
                SSM_RX: begin
                    if (!rx_want) begin
                        state_q <= SSM_IDLE;
                    end else begin
                        if (lead_edge) begin
                            phase_q <= 1'b1;
                        end
                        if (samp_edge) begin
                            // Bits enter at the top, LSB first
                            if (word_bits == SSM_BITS_9) begin
                                shift_q <= {dt_sync_q[1], shift_q[8:1]};
                            end else begin
                                shift_q <= {1'b0, dt_sync_q[1], shift_q[7:1]};
                            end
                            bit_cnt_q <= bit_cnt_q - 4'h1;
                            phase_q <= 1'b0;
                            if (bit_cnt_q == 4'h1) begin
                                // Continuous restarts; single stops
                                state_q <= cont_rx ? SSM_RX : SSM_IDLE;
                                bit_cnt_q <= word_bits;
                            end
                        end
                    end
                end
                default: state_q <= SSM_IDLE;
            endcase
        end
    end

    // Receive buffer and ninth bit, loaded at word end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf_q <= SSM_RST_ZERO;
            rx9_q <= 1'b0;
        end else if (state_q == SSM_RX && rx_want && word_end && !rx_done_q) begin
            if (word_bits == SSM_BITS_9) begin
                rx_buf_q <= shift_q[8:1];
                rx9_q <= dt_sync_q[1];
            end else begin
                rx_buf_q <= {dt_sync_q[1], shift_q[7:1]};
                rx9_q <= 1'b0;
            end
        end
    end

    // Receive-complete flag set with the buffer; a read clears it, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_done_q <= 1'b0;
        end else if (state_q == SSM_RX && rx_want && word_end) begin
            rx_done_q <= 1'b1;
        end else if (rx_read) begin
            rx_done_q <= 1'b0;
        end
    end

    // Overrun when a word ends while the buffer is unread
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overrun_q <= 1'b0;
        end else if (state_q == SSM_RX && rx_want && word_end && rx_done_q) begin
            overrun_q <= 1'b1;
        end else if (!cont_rx) begin
            overrun_q <= 1'b0;
        end
    end

    // Buffer-empty flag: set on load, cleared only by a buffer write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_empty_q <= 1'b1;
        end else if (state_q == SSM_LOAD) begin
            tx_empty_q <= 1'b1;
        end else if (buf_write) begin
            tx_empty_q <= 1'b0;
        end
    end

    // Single-receive enable self-clears after its one word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_ctl_q <= SSM_RST_ZERO;
        end else if (wr_acc && paddr == SSM_OFF_RX_STAT) begin
            rx_ctl_q <= pwdata[7:0];
        end else if (state_q == SSM_RX && word_end && !cont_rx) begin
            rx_ctl_q[SSM_BIT_SINGLE_RX] <= 1'b0;
        end
    end

    // Plain software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enables_q <= SSM_RST_ZERO;
            tx_ctl_q <= SSM_RST_ZERO;
            baud_ctl_q <= SSM_RST_ZERO;
            div_high_q <= SSM_RST_ZERO;
            div_low_q <= SSM_RST_ZERO;
            tx_buf_q <= SSM_RST_ZERO;
        end else if (wr_acc) begin
            case (paddr)
                SSM_OFF_ENABLES: enables_q <= pwdata[7:0];
                SSM_OFF_TX_STAT: tx_ctl_q <= pwdata[7:0];
                SSM_OFF_BAUD_CTL: baud_ctl_q <= pwdata[7:0];
                SSM_OFF_DIV_HIGH: div_high_q <= pwdata[7:0];
                SSM_OFF_DIV_LOW: div_low_q <= pwdata[7:0];
                SSM_OFF_TX_BUF: tx_buf_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // APB answer: zero wait states, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    SSM_OFF_FLAGS: prdata[7:0] <= {2'b00, rx_done_q, tx_empty_q, 4'h0};
                    SSM_OFF_ENABLES: prdata[7:0] <= enables_q;
                    SSM_OFF_RX_STAT: prdata[7:0] <= {rx_ctl_q[7:2], overrun_q, rx9_q};
                    SSM_OFF_TX_BUF: prdata[7:0] <= tx_buf_q;
                    SSM_OFF_TX_STAT: prdata[7:0] <= {tx_ctl_q[7:2],
                        (state_q != SSM_TX && state_q != SSM_LOAD), tx_ctl_q[0]};
                    SSM_OFF_BAUD_CTL: prdata[7:0] <= baud_ctl_q;
                    SSM_OFF_DIV_HIGH: prdata[7:0] <= div_high_q;
                    SSM_OFF_DIV_LOW: prdata[7:0] <= div_low_q;
                    SSM_OFF_RX_BUF: prdata[7:0] <= rx_buf_q;
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Pins and interrupt outputs, all registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_q <= 1'b0;
            shift_clock_pin_o <= 1'b0;
            shift_clock_pin_oe <= 1'b0;
            serial_data_pin_o <= 1'b0;
            serial_data_pin_oe <= 1'b0;
            tx_on_q <= 1'b0;
            tx_on2_q <= 1'b0;
            tx_irq <= 1'b0;
            rx_irq <= 1'b0;
        end else begin
            sck_q <= phase_q;
            // Idle level follows polarity select
            shift_clock_pin_o <= sck_q ^ baud_ctl_q[SSM_BIT_CLK_POL];
            shift_clock_pin_oe <= master;
            serial_data_pin_o <= data_out_q;
            // Data enable lags the pin clock so it outlasts the last falling edge
            tx_on_q <= port_on && (state_q == SSM_TX || state_q == SSM_LOAD);
            tx_on2_q <= tx_on_q;
            serial_data_pin_oe <= tx_on2_q;
            tx_irq <= tx_empty_q & enables_q[SSM_BIT_TX_EMPTY];
            rx_irq <= rx_done_q & enables_q[SSM_BIT_RX_DONE];
        end
    end
endmodule : ssm_sync_serial

// >>> verif/ssm_chk.sv
// Checker for the serial block: APB answers and shift-pin timing.
// Assumes it is bound to ssm_sync_serial and sees its ports only.
`timescale 1ns/1ps
module ssm_chk
    import ssm_pkg::*;
(
    // APB side
    input wire logic pclk, presetn, psel, penable, pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic pready, pslverr,
    // Pins and requests
    input wire logic shift_clock_pin_i, shift_clock_pin_o, shift_clock_pin_oe,
    input wire logic serial_data_pin_i, serial_data_pin_o, serial_data_pin_oe,
    input wire logic tx_irq, rx_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic pol_q;
    logic txw_q;
    wire acc = psel && penable && pready && pwrite;
    // Clock polarity as last written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pol_q <= 1'b0;
        end else if (acc && paddr == SSM_OFF_BAUD_CTL) begin
            pol_q <= pwdata[SSM_BIT_CLK_POL];
        end
    end
    // Buffer written but word not yet started
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txw_q <= 1'b0;
        end else if (acc && paddr == SSM_OFF_TX_BUF) begin
            txw_q <= 1'b1;
        end else if ($rose(serial_data_pin_oe)) begin
            txw_q <= 1'b0;
        end
    end
    sequence s_setup; psel && !penable; endsequence
    sequence s_slave; acc && paddr == SSM_OFF_TX_STAT && !pwdata[SSM_BIT_CLK_SRC]; endsequence
    property p_answer; s_setup |=> pready; endproperty
    property p_pulse; pready |=> !pready; endproperty
    property p_access; pready |-> psel && penable; endproperty
    property p_unmapped; s_setup ##0 paddr >= 8'h24 |=> pslverr && prdata == 32'h0; endproperty
    property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
    property p_idle_pol; $rose(shift_clock_pin_oe) |-> shift_clock_pin_o == pol_q; endproperty
    property p_edge;
        shift_clock_pin_oe && serial_data_pin_oe && $past(serial_data_pin_oe)
            && $changed(serial_data_pin_o)
            |-> !(pol_q ? $rose(shift_clock_pin_o) : $fell(shift_clock_pin_o));
    endproperty
    property p_start; $rose(serial_data_pin_oe) |-> txw_q; endproperty
    property p_slave; s_slave |-> ##3 !shift_clock_pin_oe; endproperty
    a_answer: assert property (p_answer) else $error("no answer after setup");
    a_pulse: assert property (p_pulse) else $error("ready held too long");
    a_access: assert property (p_access) else $error("ready outside access");
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
    a_upper: assert property (p_upper) else $error("upper read bits set");
    a_idle_pol: assert property (p_idle_pol) else $error("idle clock level");
    a_edge: assert property (p_edge) else $error("data moved on sampling edge");
    a_start: assert property (p_start) else $error("word without write");
    a_slave: assert property (p_slave) else $error("clock driven in slave");
endmodule : ssm_chk
bind ssm_sync_serial ssm_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .shift_clock_pin_i(shift_clock_pin_i),
    .shift_clock_pin_o(shift_clock_pin_o), .shift_clock_pin_oe(shift_clock_pin_oe),
    .serial_data_pin_i(serial_data_pin_i), .serial_data_pin_o(serial_data_pin_o),
    .serial_data_pin_oe(serial_data_pin_oe), .tx_irq(tx_irq), .rx_irq(rx_irq));

// >>> verif/ssm_peer.sv
// Far-side serial device: takes words, feeds receive data, clocks slave frames.
// Assumes idle-low clock in master mode; slave clock period 80 ns.
`timescale 1ns/1ps
module ssm_peer (
    // Resolved pins
    input wire logic sck, sck_oe, sd, sd_oe,
    // Driven by this model
    output logic ext_clk, dat
);
    logic [17:0] cap;
    int cap_n;
    logic [7:0] rx_word;
    int rx_idx;
    initial begin
        ext_clk = 1'b0;
        dat = 1'b0;
        cap = '0;
        cap_n = 0;
        rx_word = 8'h00;
        rx_idx = 0;
    end
    // Take sent bits on falling edge, or step the receive bit
    always @(negedge sck) begin
        if (sck_oe && sd_oe && cap_n < 18) begin
            cap[cap_n] = sd;
            cap_n++;
        end else if (sck_oe && !sd_oe) begin
            rx_idx = (rx_idx + 1) % 8;
        end
    end
    // New bit after rising edge, stable at falling
    always @(posedge sck) begin
        if (sck_oe && !sd_oe) dat = rx_word[rx_idx];
    end
    task automatic load(input logic [7:0] w);
        rx_word = w;
        rx_idx = 0;
        dat = w[0];
    endtask : load
    // Eight slave clocks; sample late in the low half
    task automatic slave_word();
        repeat (8) begin
            #2 ext_clk = 1'b1;
            #40 ext_clk = 1'b0;
            #36 cap[cap_n] = sd;
            cap_n++;
            #2;
        end
    endtask : slave_word
endmodule : ssm_peer

// >>> verif/tb_sync_serial_master_slave.sv
// Bench for the serial block: APB tasks and one task per scenario.
// Assumes ssm_peer on the pins and the checker bound from its own file.
`timescale 1ns/1ps
module tb_sync_serial_master_slave
    import ssm_pkg::*;
();
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic sck_o, sck_oe, sd_o, sd_oe, tx_irq, rx_irq, ext_clk, pdat;
    wire sck_w = sck_oe ? sck_o : ext_clk;
    wire sd_w = sd_oe ? sd_o : pdat;
    int failures = 0;
    int cmp_count = 0;
    ssm_sync_serial dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .shift_clock_pin_i(sck_w), .shift_clock_pin_o(sck_o),
        .shift_clock_pin_oe(sck_oe), .serial_data_pin_i(sd_w), .serial_data_pin_o(sd_o),
        .serial_data_pin_oe(sd_oe), .tx_irq(tx_irq), .rx_irq(rx_irq));
    ssm_peer peer (.sck(sck_w), .sck_oe(sck_oe), .sd(sd_w), .sd_oe(sd_oe),
        .ext_clk(ext_clk), .dat(pdat));
    task automatic final_report();
        $display("failures %0d compares %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One APB transfer, held until ready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n == 20) begin
            failures++;
            final_report();
        end
    endtask : apb
    task automatic wait_bit(input logic [7:0] a, input int b);
        int k;
        k = 0;
        do begin
            apb(1'b0, a, 32'h0);
            k++;
        end while (q[b] !== 1'b1 && k < 300);
        if (k == 300) begin
            failures++;
            final_report();
        end
    endtask : wait_bit
    task automatic t_regs();
        apb(1'b0, SSM_OFF_FLAGS, 32'h0);
        chk(q, 32'h10);
        apb(1'b0, SSM_OFF_TX_STAT, 32'h0);
        chk(q, 32'h02);
        apb(1'b0, 8'h24, 32'h0);
        chk({q[30:0], e}, 32'h1);
        apb(1'b1, SSM_OFF_FLAGS, 32'h0);
        apb(1'b1, SSM_OFF_TX_STAT, 32'h0);
        apb(1'b0, SSM_OFF_FLAGS, 32'h0);
        chk(q, 32'h10);
        apb(1'b0, SSM_OFF_TX_STAT, 32'h0);
        chk(q, 32'h02);
        apb(1'b1, SSM_OFF_ENABLES, 32'h10);
        @(posedge pclk);
        chk({31'h0, tx_irq}, 32'h1);
        apb(1'b1, SSM_OFF_ENABLES, 32'h0);
    endtask : t_regs
    task automatic t_pol();
        apb(1'b1, SSM_OFF_BAUD_CTL, 32'h10);
        apb(1'b1, SSM_OFF_RX_STAT, 32'h80);
        apb(1'b1, SSM_OFF_TX_STAT, 32'h90);
        @(posedge pclk);
        chk({31'h0, sck_w}, 32'h1);
        apb(1'b1, SSM_OFF_TX_STAT, 32'h0);
        apb(1'b1, SSM_OFF_BAUD_CTL, 32'h0);
    endtask : t_pol
    task automatic wait_cap(input int n);
        int k;
        k = 0;
        while (peer.cap_n < n && k < 3000) begin
            @(posedge pclk);
            k++;
        end
        chk(peer.cap_n, n);
        if (peer.cap_n < n) final_report();
    endtask : wait_cap
    task automatic t_tx();
        apb(1'b1, SSM_OFF_DIV_LOW, 32'h7);
        apb(1'b1, SSM_OFF_TX_STAT, 32'hb0);
        peer.cap_n = 0;
        apb(1'b1, SSM_OFF_TX_BUF, 32'ha5);
        apb(1'b1, SSM_OFF_TX_BUF, 32'h3c);
        apb(1'b0, SSM_OFF_FLAGS, 32'h0);
        chk(q, 32'h00);
        wait_cap(16);
        chk({16'h0, peer.cap[15:0]}, 32'h3ca5);
        wait_bit(SSM_OFF_TX_STAT, SSM_BIT_SHIFT_EMPTY);
        apb(1'b0, SSM_OFF_FLAGS, 32'h0);
        chk(q, 32'h10);
        apb(1'b1, SSM_OFF_TX_STAT, 32'hf1);
        peer.cap_n = 0;
        apb(1'b1, SSM_OFF_TX_BUF, 32'h5a);
        wait_cap(9);
        chk({23'h0, peer.cap[8:0]}, 32'h15a);
        wait_bit(SSM_OFF_TX_STAT, SSM_BIT_SHIFT_EMPTY);
    endtask : t_tx
    task automatic t_rx();
        apb(1'b1, SSM_OFF_TX_STAT, 32'h90);
        peer.load(8'hc6);
        apb(1'b1, SSM_OFF_ENABLES, 32'h20);
        apb(1'b1, SSM_OFF_RX_STAT, 32'ha0);
        wait_bit(SSM_OFF_FLAGS, SSM_BIT_RX_DONE);
        chk({31'h0, rx_irq}, 32'h1);
        apb(1'b0, SSM_OFF_RX_STAT, 32'h0);
        chk(q, 32'h80);
        apb(1'b0, SSM_OFF_RX_BUF, 32'h0);
        chk(q, 32'hc6);
        @(posedge pclk);
        chk({31'h0, rx_irq}, 32'h0);
        repeat (300) @(posedge pclk);
        apb(1'b0, SSM_OFF_FLAGS, 32'h0);
        chk(q, 32'h10);
        peer.load(8'h39);
        apb(1'b1, SSM_OFF_RX_STAT, 32'hb0);
        repeat (2) begin
            wait_bit(SSM_OFF_FLAGS, SSM_BIT_RX_DONE);
            apb(1'b0, SSM_OFF_RX_BUF, 32'h0);
            chk(q, 32'h39);
        end
        repeat (600) @(posedge pclk);
        apb(1'b0, SSM_OFF_RX_STAT, 32'h0);
        chk(q & 32'h2, 32'h2);
        apb(1'b1, SSM_OFF_RX_STAT, 32'h80);
        apb(1'b0, SSM_OFF_RX_STAT, 32'h0);
        chk(q, 32'h80);
        apb(1'b0, SSM_OFF_RX_BUF, 32'h0);
    endtask : t_rx
    task automatic t_slave();
        apb(1'b1, SSM_OFF_TX_STAT, 32'h30);
        @(posedge pclk);
        chk({31'h0, sck_oe}, 32'h0);
        peer.cap_n = 0;
        apb(1'b1, SSM_OFF_TX_BUF, 32'h96);
        repeat (10) @(posedge pclk);
        peer.slave_word();
        @(posedge pclk);
        wait_bit(SSM_OFF_TX_STAT, SSM_BIT_SHIFT_EMPTY);
        chk({24'h0, peer.cap[7:0]}, 32'h96);
    endtask : t_slave
    // System clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Hang guard
    initial begin
        repeat (60000) @(posedge pclk);
        failures++;
        final_report();
    end
    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_pol();
        t_tx();
        t_rx();
        t_slave();
        final_report();
    end
endmodule : tb_sync_serial_master_slave
